/* tma_mem_model.sv */
// Behavioural traffic memory facing the port's memory pins
`timescale 1ns/100ps
module tma_mem_model
  import tma_pkg::*;
(
  // Clock and pacing, zero means always ready
  input  wire logic              mclk,
  input  wire logic [9:0]        slow,
  // Memory pins
  input  wire logic              memory_chip_select_n,
  input  wire logic              memory_read_strobe_n,
  input  wire logic              memory_write_strobe_n,
  output logic                   memory_ready_input_n,
  input  wire logic [ADDR_W-1:0] mem_addr_o,
  input  wire logic              mem_addr_oe,
  input  wire logic [DATA_W-1:0] mem_data_o,
  input  wire logic              mem_data_oe,
  output logic [DATA_W-1:0]      mem_data_i,
  // Strobe widths in tenths of a nanosecond
  output int                     rd_len,
  output int                     wr_len
);
  logic [DATA_W-1:0] mem[int];
  logic [DATA_W-1:0] last = 16'h0000;
  int                cnt = 0;
  realtime           t_rd, t_wr;

  // ************************************************************
  // Answers
  // ************************************************************
  // A slow memory stretches with its ready pin rather than late data
  assign memory_ready_input_n = (slow != 0) && (memory_chip_select_n || cnt < slow);
  always @(posedge mclk) begin
    cnt <= memory_chip_select_n ? 0 : cnt + 1;
    last <= mem_data_i;
  end
  // Unselected bus toggles, so a stale value can never match by luck
  always @* begin
    if (!memory_chip_select_n && mem_addr_oe && mem.exists(mem_addr_o))
      mem_data_i = mem[mem_addr_o];
    else
      mem_data_i = ~last;
  end
  always @(posedge memory_write_strobe_n) if (mem_data_oe) mem[mem_addr_o] = mem_data_o;
  // Strobe widths for the bench
  always @(negedge memory_read_strobe_n) t_rd = $realtime;
  always @(posedge memory_read_strobe_n) rd_len = int'(($realtime - t_rd) * 10);
  always @(negedge memory_write_strobe_n) t_wr = $realtime;
  always @(posedge memory_write_strobe_n) wr_len = int'(($realtime - t_wr) * 10);
endmodule

/* tma_pkg.sv */
// Constants, carrier types and states for the traffic memory access port
package tma_pkg;

  // ****************************************************************
  // Widths and clock
  // ****************************************************************
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int CLK_PERIOD_PS = 25000;  // 40 MHz

  // ****************************************************************
  // Access timing, counted in clock periods
  // ****************************************************************
  localparam logic [1:0] ARB_LAST  = 2'h1;   // Two-period arbitration switch: counts 0,1
  localparam logic [6:0] RD_BASE   = 7'h02;  // Read strobe without wait states
  localparam logic [6:0] HWR_BASE  = 7'h02;  // Host write strobe without wait states
  localparam logic [6:0] OWR_BASE  = 7'h01;  // Own write: one period plus half from negedge
  localparam logic [6:0] MAX_ADDED = 7'h3F;  // Added cycles before forced termination

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } tma_own_req_t;

  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_pos;
    logic aen_n;
    logic den_n;
    logic dir;
    logic ack_n;
    logic rdy_n;
    logic maddr_oe;
    logic mdata_oe;
  } tma_ctl_t;

  localparam tma_ctl_t CTL_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, wr_pos: 1'b0, aen_n: 1'b1,
                                    den_n: 1'b1, dir: 1'b0, ack_n: 1'b1, rdy_n: 1'b1,
                                    maddr_oe: 1'b0, mdata_oe: 1'b0};

  typedef enum logic [5:0] {
    ST_IDLE    = 6'h01,
    ST_ARB     = 6'h02,
    ST_SETUP   = 6'h04,
    ST_STRB    = 6'h08,
    ST_HOLD    = 6'h10,
    ST_RELEASE = 6'h20
  } tma_state_t;

endpackage

/* tma_port.sv */
// Traffic memory access port: shares the memory between own logic and the host
//
// Overview of operation
// RULE1: [RULE1] Host read and write strobes are synchronised before memory strobes assert.
// RULE2: [RULE2] Host access is select plus a strobe; the strobe alone picks read or write.
// RULE3: [RULE3] Host holds its strobe until ready goes low; no further hold needed.
// RULE4: [RULE4] Host select is sampled on a rising edge and acted on next cycle.
// RULE5: [RULE5] Memory ready is sampled and acted on next cycle; inactive ready extends.
// RULE6: [RULE6] Own reads hold the memory read strobe two periods without waits.
// RULE7: [RULE7] Own writes hold the write strobe one and a half periods, falling-edge end.
// RULE8: [RULE8] Host reads drive the memory read strobe two periods without waits.
// RULE9: [RULE9] Host writes drive the memory write strobe two periods without waits.
// RULE10: [RULE10] Driven address is valid one period before the read strobe.
// RULE11: [RULE11] Driven address stays stable one period after the read strobe ends.
// RULE12: [RULE12] Own write data stays driven half a period after the write strobe.
// RULE13: [RULE13] Host address is valid by its strobe edge and held until the strobe rises.
// RULE14: [RULE14] Host read data reaches the host two periods after read recognition.
// RULE15: [RULE15] Slow memory must stretch the access with waits or its ready input.
// RULE16: [RULE16] Add 0-3 configured waits plus ready waits; force end after 63 added.
// RULE17: [RULE17] An ownership switch between device and host takes at least two periods.
// RULE18: [RULE18] After a switch, buffer enable and chip select assert, strobe one later.
// RULE19: [RULE19] Host select lasts four periods; read strobe three, write two and a half.
// RULE20: [RULE20] Host ready never stays inactive over 65 periods; forced end raises it. Code: on a forced read, ready goes active 67 periods after acknowledge.
`timescale 1ns/100ps
module tma_port
  import tma_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              nrst,
  // Configuration
  input  wire logic [1:0]        wait_states,
  // Host pins
  input  wire logic              host_memory_select_n,
  input  wire logic              host_rd_n,
  input  wire logic              host_wr_n,
  output logic                   host_ready_n,
  output logic                   host_acknowledge_n,
  // Own access port
  input  wire logic              own_valid,
  input  wire tma_own_req_t      own_req,
  output logic                   own_ready,
  output logic                   own_done,
  output logic [DATA_W-1:0]      own_rdata,
  // Memory control pins
  output logic                   memory_chip_select_n,
  output logic                   memory_read_strobe_n,
  output logic                   memory_write_strobe_n,
  input  wire logic              memory_ready_input_n,
  output logic                   addr_buf_en_n,
  output logic                   data_buf_en_n,
  output logic                   data_dir,
  // Memory address and data bus
  output logic [ADDR_W-1:0]      mem_addr_o,
  output logic                   mem_addr_oe,
  input  wire logic [DATA_W-1:0] mem_data_i,
  output logic [DATA_W-1:0]      mem_data_o,
  output logic                   mem_data_oe
);

  // ****************************************************************
  // Reset release and pin synchronisers
  // ****************************************************************
  logic [1:0] rst_sync_q;
  logic       rst_n;

  // Assert at once, release through two flops
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  logic [DATA_W-1:0] mdata_s;
  logic [3:0]        pins_s;
  logic              sel_s;
  logic              rd_s;
  logic              wr_s;
  logic              mrdy_s;

  // Pins are active low; synchronised high is the idle level
  tma_sync #(.W(4), .INIT(4'hF)) u_pin_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     ({host_memory_select_n, host_rd_n, host_wr_n, memory_ready_input_n}),
    .q     (pins_s)
  );

  // Read data also passes two flops; it is stable while the strobe is held
  tma_sync #(.W(DATA_W), .INIT('0)) u_data_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     (mem_data_i),
    .q     (mdata_s)
  );

  assign sel_s  = ~pins_s[3];  // [RULE4]
  assign rd_s   = ~pins_s[2];  // [RULE1]
  assign wr_s   = ~pins_s[1];  // [RULE1]
  assign mrdy_s = ~pins_s[0];  // [RULE5]

  // ****************************************************************
  // Access sequencer
  // ****************************************************************
  tma_state_t        state_q, state_d;
  logic [1:0]        arb_q, arb_d;
  logic [6:0]        cnt_q, cnt_d;
  logic              owner_host_q, owner_host_d;
  logic              tgt_host_q, tgt_host_d;
  logic              is_wr_q, is_wr_d;
  tma_own_req_t      req_q, req_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic              done_q, done_d;
  tma_ctl_t          ctl_q, ctl_d;
  logic              half_q;
  logic              host_req;
  logic [6:0]        base;
  logic [6:0]        min_len;
  logic [6:0]        elapsed;
  logic [6:0]        added;
  logic              strb_end;

  // Access is select with a strobe; the strobe alone picks the direction
  assign host_req = sel_s & (rd_s | wr_s);  // [RULE2]

  // Base strobe length per kind of access
  always_comb begin
    if (!is_wr_q) begin
      base = RD_BASE;  // [RULE6] [RULE8]
    end else if (tgt_host_q) begin
      base = HWR_BASE;  // [RULE9]
    end else begin
      base = OWR_BASE;  // [RULE7]
    end
  end

  // Waits are added on top of the base; ready is only looked at after them
  assign min_len  = base + {5'h00, wait_states};  // [RULE16]
  assign elapsed  = cnt_q + 7'h01;
  assign added    = elapsed - base;
  assign strb_end = (elapsed >= min_len) && (mrdy_s || (added >= MAX_ADDED));  // [RULE5] [RULE16]

  // Next state and registered outputs
  always_comb begin
    state_d      = state_q;
    arb_d        = arb_q;
    cnt_d        = cnt_q;
    owner_host_d = owner_host_q;
    tgt_host_d   = tgt_host_q;
    is_wr_d      = is_wr_q;
    req_d        = req_q;
    rdata_d      = rdata_q;
    done_d       = 1'b0;
    own_ready    = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        arb_d = 2'h0;
        cnt_d = 7'h00;
        // Host goes first; the own port waits for the next idle slot
        if (host_req) begin
          tgt_host_d = 1'b1;
          is_wr_d    = wr_s & ~rd_s;  // [RULE2]
          state_d    = owner_host_q ? ST_SETUP : ST_ARB;  // [RULE17]
        end else if (own_valid) begin
          own_ready  = 1'b1;
          tgt_host_d = 1'b0;
          is_wr_d    = own_req.we;
          req_d      = own_req;
          state_d    = owner_host_q ? ST_ARB : ST_SETUP;  // [RULE17]
        end
      end
      ST_ARB: begin
        arb_d = arb_q + 2'h1;
        if (arb_q == ARB_LAST) begin
          owner_host_d = tgt_host_q;
          state_d      = ST_SETUP;  // [RULE17]
        end
      end
      ST_SETUP: begin
        state_d = ST_STRB;  // [RULE10] [RULE18]
      end
      ST_STRB: begin
        cnt_d = elapsed;
        if (strb_end) begin
          state_d = ST_HOLD;
          if (!is_wr_q) begin
            rdata_d = mdata_s;
          end
        end
      end
      ST_HOLD: begin
        if (tgt_host_q) begin
          state_d = ST_RELEASE;  // [RULE14] [RULE20]
        end else begin
          done_d  = 1'b1;
          state_d = ST_IDLE;
        end
      end
      ST_RELEASE: begin
        // Ready stays low until the host lets its strobe go
        if (!(rd_s || wr_s)) begin
          state_d = ST_IDLE;  // [RULE3]
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase

    // Pin levels follow the next state so that they come straight from flops
    ctl_d = CTL_IDLE;
    if (state_d inside {ST_SETUP, ST_STRB, ST_HOLD}) begin
      ctl_d.cs_n     = 1'b0;  // [RULE18]
      ctl_d.maddr_oe = ~tgt_host_d;  // [RULE11]
      ctl_d.mdata_oe = ~tgt_host_d & is_wr_d;  // [RULE12]
    end
    if (state_d == ST_STRB) begin
      ctl_d.rd_n   = is_wr_d;  // [RULE6] [RULE8]
      ctl_d.wr_pos = is_wr_d;  // [RULE7] [RULE9]
    end
    if (tgt_host_d && (state_d inside {ST_SETUP, ST_STRB, ST_HOLD, ST_RELEASE})) begin
      ctl_d.aen_n = 1'b0;  // [RULE13] [RULE18]
      ctl_d.den_n = 1'b0;
      ctl_d.dir   = is_wr_d;
      ctl_d.ack_n = 1'b0;
    end
    if (state_d == ST_RELEASE) begin
      ctl_d.rdy_n = 1'b0;  // [RULE20]
    end
  end

  // Sequencer registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q      <= ST_IDLE;
      arb_q        <= 2'h0;
      cnt_q        <= 7'h00;
      owner_host_q <= 1'b0;
      tgt_host_q   <= 1'b0;
      is_wr_q      <= 1'b0;
      req_q        <= '0;
      rdata_q      <= '0;
      done_q       <= 1'b0;
      ctl_q        <= CTL_IDLE;
    end else begin
      state_q      <= state_d;
      arb_q        <= arb_d;
      cnt_q        <= cnt_d;
      owner_host_q <= owner_host_d;
      tgt_host_q   <= tgt_host_d;
      is_wr_q      <= is_wr_d;
      req_q        <= req_d;
      rdata_q      <= rdata_d;
      done_q       <= done_d;
      ctl_q        <= ctl_d;
    end
  end

  // ****************************************************************
  // Half-period write extension
  // ****************************************************************
  // Own writes end on a falling edge, half a period after the strobe flop drops
  always_ff @(negedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      half_q <= 1'b0;
    end else begin
      half_q <= ctl_q.wr_pos & ~tgt_host_q;  // [RULE7]
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign memory_chip_select_n  = ctl_q.cs_n;
  assign memory_read_strobe_n  = ctl_q.rd_n;
  assign memory_write_strobe_n = ~(ctl_q.wr_pos | half_q);  // [RULE7]
  assign addr_buf_en_n         = ctl_q.aen_n;
  assign data_buf_en_n         = ctl_q.den_n;
  assign data_dir              = ctl_q.dir;
  assign host_acknowledge_n    = ctl_q.ack_n;
  assign host_ready_n          = ctl_q.rdy_n;
  assign mem_addr_oe           = ctl_q.maddr_oe;
  assign mem_data_oe           = ctl_q.mdata_oe;
  assign mem_addr_o            = req_q.addr;
  assign mem_data_o            = req_q.wdata;  // Held through the hold period [RULE12]
  assign own_rdata             = rdata_q;
  assign own_done              = done_q;

endmodule

/* tma_port_sva.sv */
// Pin-level checker for the traffic memory access port
`timescale 1ns/100ps
module tma_port_sva
  import tma_pkg::*;
(
  // Clock and reset
  input wire logic              mclk,
  input wire logic              nrst,
  // Host pins
  input wire logic              host_memory_select_n,
  input wire logic              host_rd_n,
  input wire logic              host_wr_n,
  input wire logic              host_ready_n,
  input wire logic              host_acknowledge_n,
  // Own port
  input wire logic              own_ready,
  input wire logic              own_done,
  // Memory pins
  input wire logic              memory_chip_select_n,
  input wire logic              memory_read_strobe_n,
  input wire logic              memory_write_strobe_n,
  input wire logic              addr_buf_en_n,
  input wire logic [ADDR_W-1:0] mem_addr_o,
  input wire logic              mem_addr_oe,
  input wire logic [DATA_W-1:0] mem_data_o,
  input wire logic              mem_data_oe
);
  // ************************************************************
  // Relations between pins
  // ************************************************************
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  chk_one_strobe: assert property (
    !(!memory_read_strobe_n && !memory_write_strobe_n)) else $error("both strobes low");
  chk_sync_first: assert property (
    $fell(host_acknowledge_n) |-> !$past(host_memory_select_n, 2)
      && !($past(host_rd_n, 2) && $past(host_wr_n, 2))) else $error("host served before sync");
  chk_ready_held: assert property (
    !host_ready_n && !(host_rd_n && host_wr_n) |=> !host_ready_n) else $error("ready dropped");
  chk_ready_bound: assert property (
    $fell(host_acknowledge_n) |-> ##[1:68] !host_ready_n) else $error("host ready late");
  chk_addr_setup: assert property (
    $fell(memory_read_strobe_n) && mem_addr_oe |-> $past(mem_addr_oe) && $stable(mem_addr_o))
    else $error("address not set up");
  chk_addr_hold: assert property (
    $rose(memory_read_strobe_n) && $past(mem_addr_oe) |-> mem_addr_oe && $stable(mem_addr_o))
    else $error("address not held");
  chk_cs_then_strobe: assert property (
    $fell(addr_buf_en_n) |-> $fell(memory_chip_select_n) && memory_read_strobe_n
      && memory_write_strobe_n ##1 !(memory_read_strobe_n && memory_write_strobe_n))
    else $error("buffer, select, strobe order");
  chk_host_rd_len: assert property (
    $fell(memory_read_strobe_n) && !addr_buf_en_n |-> (!memory_read_strobe_n) [*2])
    else $error("host read strobe short");
  chk_own_data_hold: assert property (
    $rose(memory_write_strobe_n) && $past(mem_data_oe) |-> mem_data_oe && $stable(mem_data_o))
    else $error("write data not held");
  chk_own_done_bound: assert property (
    own_ready |-> ##[3:80] own_done) else $error("own access not ended");
endmodule

bind tma_port tma_port_sva chk_u (
  .mclk                  (mclk),
  .nrst                  (nrst),
  .host_memory_select_n  (host_memory_select_n),
  .host_rd_n             (host_rd_n),
  .host_wr_n             (host_wr_n),
  .host_ready_n          (host_ready_n),
  .host_acknowledge_n    (host_acknowledge_n),
  .own_ready             (own_ready),
  .own_done              (own_done),
  .memory_chip_select_n  (memory_chip_select_n),
  .memory_read_strobe_n  (memory_read_strobe_n),
  .memory_write_strobe_n (memory_write_strobe_n),
  .addr_buf_en_n         (addr_buf_en_n),
  .mem_addr_o            (mem_addr_o),
  .mem_addr_oe           (mem_addr_oe),
  .mem_data_o            (mem_data_o),
  .mem_data_oe           (mem_data_oe)
);

/* tma_sync.sv */
// Two-flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/100ps
module tma_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // Levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  // First stage is read only by the second stage
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= INIT;
      q      <= INIT;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

/* traffic_memory_access_port_test.sv */
// Self-checking bench for the traffic memory access port
`timescale 1ns/100ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module traffic_memory_access_port_test
  import tma_pkg::*;
;
  logic              mclk = 1'b0;
  logic              nrst, host_memory_select_n, host_rd_n, host_wr_n;
  logic              host_ready_n, host_acknowledge_n, own_valid, own_ready, own_done;
  logic              memory_chip_select_n, memory_read_strobe_n, memory_write_strobe_n;
  logic              memory_ready_input_n, addr_buf_en_n, data_buf_en_n, data_dir;
  logic              mem_addr_oe, mem_data_oe;
  logic [1:0]        wait_states;
  logic [9:0]        slow;
  logic [ADDR_W-1:0] mem_addr_o, a;
  logic [DATA_W-1:0] own_rdata, mem_data_i, mem_data_o, d;
  logic [15:0]       lfsr;
  logic [15:0]       exp_mem[int];
  tma_own_req_t      own_req;
  int                cyc = 0;
  int                err_count, cmp_count, done_cyc, ack_cyc, rdy_cyc, rd_len, wr_len;

  // Device under test
  tma_port dut_u (
    .mclk                  (mclk),
    .nrst                  (nrst),
    .wait_states           (wait_states),
    .host_memory_select_n  (host_memory_select_n),
    .host_rd_n             (host_rd_n),
    .host_wr_n             (host_wr_n),
    .host_ready_n          (host_ready_n),
    .host_acknowledge_n    (host_acknowledge_n),
    .own_valid             (own_valid),
    .own_req               (own_req),
    .own_ready             (own_ready),
    .own_done              (own_done),
    .own_rdata             (own_rdata),
    .memory_chip_select_n  (memory_chip_select_n),
    .memory_read_strobe_n  (memory_read_strobe_n),
    .memory_write_strobe_n (memory_write_strobe_n),
    .memory_ready_input_n  (memory_ready_input_n),
    .addr_buf_en_n         (addr_buf_en_n),
    .data_buf_en_n         (data_buf_en_n),
    .data_dir              (data_dir),
    .mem_addr_o            (mem_addr_o),
    .mem_addr_oe           (mem_addr_oe),
    .mem_data_i            (mem_data_i),
    .mem_data_o            (mem_data_o),
    .mem_data_oe           (mem_data_oe)
  );

  // Memory at the far side of the port
  tma_mem_model mem_u (
    .mclk                  (mclk),
    .slow                  (slow),
    .memory_chip_select_n  (memory_chip_select_n),
    .memory_read_strobe_n  (memory_read_strobe_n),
    .memory_write_strobe_n (memory_write_strobe_n),
    .memory_ready_input_n  (memory_ready_input_n),
    .mem_addr_o            (mem_addr_o),
    .mem_addr_oe           (mem_addr_oe),
    .mem_data_o            (mem_data_o),
    .mem_data_oe           (mem_data_oe),
    .mem_data_i            (mem_data_i),
    .rd_len                (rd_len),
    .wr_len                (wr_len)
  );

  // ************************************************************
  // Clock, timeout and helpers
  // ************************************************************
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Own request: held until taken, then wait for the end pulse
  task automatic own_acc(input logic we);
    own_req = '{we: we, addr: a, wdata: d};
    own_valid = 1'b1;
    do @(negedge mclk); while (own_ready !== 1'b1);
    @(posedge mclk) #2;
    own_valid = 1'b0;
    do @(posedge mclk) #2; while (own_done !== 1'b1);
    done_cyc = cyc;
    if (we) exp_mem[a] = d;
    else `CHK("own_rdata", exp_mem[a], own_rdata)
  endtask
  // Host access: strobe kept until ready falls, then passive until ready rises, plus one period
  task automatic host_acc(input logic rd);
    host_memory_select_n = 1'b0;
    host_rd_n = !rd;
    host_wr_n = rd;
    do @(posedge mclk) #2; while (host_acknowledge_n !== 1'b0);
    ack_cyc = cyc;
    // Buffers face the host while its access is served; own address pins stay off
    `CHK("data_dir", !rd, data_dir)
    `CHK("data_buf_en_n", 1'b0, data_buf_en_n)
    `CHK("host_addr_oe", 1'b0, mem_addr_oe)
    do @(posedge mclk) #2; while (host_ready_n !== 1'b0);
    rdy_cyc = cyc;
    {host_memory_select_n, host_rd_n, host_wr_n} = 3'h7;
    do @(posedge mclk) #2; while (host_ready_n !== 1'b1);
    @(posedge mclk) #2;
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    {nrst, own_valid, slow, wait_states, err_count, cmp_count} = '0;
    {host_memory_select_n, host_rd_n, host_wr_n} = 3'h7;
    own_req = '0;
    lfsr = 16'h7F88;
    repeat (10) @(posedge mclk);
    #2 nrst = 1'b1;
    repeat (3) @(posedge mclk) #2;
    // Every wait setting, own and host traffic, random places and data
    for (int w = 0; w < 4; w++) begin
      wait_states = w[1:0];
      lfsr = nxt(lfsr);
      a[19:16] = lfsr[3:0];
      lfsr = nxt(lfsr);
      a[15:0] = lfsr;
      d = nxt(lfsr);
      own_acc(1'b1);
      `CHK("own_wr_len", 375 + 250 * w, wr_len)
      own_acc(1'b0);
      `CHK("own_rd_len", 500 + 250 * w, rd_len)
      host_acc(1'b1);
      `CHK("host_rd_len", 500 + 250 * w, rd_len)
      host_acc(1'b0);
      `CHK("host_wr_len", 500 + 250 * w, wr_len)
    end
    // Host arrives while an own read runs: switch only after it ends
    wait_states = 2'h0;
    fork
      own_acc(1'b0);
      begin
        repeat (2) @(posedge mclk) #2;
        host_acc(1'b1);
      end
    join
    `CHK("switch_gap", 1'b1, (ack_cyc - done_cyc) >= 2)
    // Slow memory stretches the strobe
    slow = 10'h005;
    host_acc(1'b0);
    `CHK("stretched", 1'b1, wr_len > 500)
    // Memory never ready: forced end
    slow = 10'h3FF;
    host_acc(1'b1);
    // Setup, base strobe plus 63 added cycles, then hold before ready
    `CHK("forced_host", int'(RD_BASE) + int'(MAX_ADDED) + 2, rdy_cyc - ack_cyc)
    `CHK("forced_rd_len", 250 * (int'(RD_BASE) + int'(MAX_ADDED)), rd_len)
    own_acc(1'b0);
    `CHK("forced_own_len", 250 * (int'(RD_BASE) + int'(MAX_ADDED)), rd_len)
    slow = 10'h000;
    finish_test();
  end
endmodule
